// File: rtl/tmc_cfg.svh
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// Bus geometry
`define TMC_ADDR_W 12
`define TMC_IDX_W 10

// Register indices, byte address is index times four
`define TMC_FLAG_IDX 10'h00c
`define TMC_CNTL_IDX 10'h00e
`define TMC_CNTH_IDX 10'h00f
`define TMC_CTRL_IDX 10'h010
`define TMC_IEN_IDX 10'h08c

// Control register fields
`define TMC_B_RUN 0
`define TMC_B_CS 1
`define TMC_B_SYNC 2
`define TMC_B_OSC 3
`define TMC_B_PS_LO 4
`define TMC_B_PS_HI 5
`define TMC_CTRL_MASK 8'h3f
`define TMC_CTRL_RST 8'h00

// Flag and enable bit position
`define TMC_B_OVF 0

// Counter limits
`define TMC_CNT_MAX 16'hffff
`define TMC_CNT_ZERO 16'h0000

// Phase clocks of one instruction cycle
`define TMC_Q2 2'h1
`define TMC_Q4 2'h3

// Bus responses
`define TMC_RESP_OK 2'h0
`define TMC_RESP_ERR 2'h2

`endif

// File: rtl/tmc_pkg.sv
package tmc_pkg;

    typedef enum logic [1:0] {
        TMC_WS_IDLE = 2'h0,
        TMC_WS_ADDR = 2'h1,
        TMC_WS_RESP = 2'h3,
        TMC_WS_DATA = 2'h2
    } tmc_wr_st_t;

    typedef enum logic {
        TMC_RS_IDLE = 1'b0,
        TMC_RS_DATA = 1'b1
    } tmc_rd_st_t;

    typedef enum logic [2:0] {
        TMC_SEL_NONE = 3'h0,
        TMC_SEL_FLAG = 3'h1,
        TMC_SEL_CNTL = 3'h2,
        TMC_SEL_CNTH = 3'h3,
        TMC_SEL_CTRL = 3'h4,
        TMC_SEL_IEN = 3'h5
    } tmc_sel_t;

    typedef enum logic [1:0] {
        TMC_MODE_TIMER = 2'h0,
        TMC_MODE_SYNC = 2'h1,
        TMC_MODE_ASYNC = 2'h3
    } tmc_mode_t;

endpackage

// File: rtl/tmc_presc.sv
`timescale 1ns/10ps
`include "tmc_cfg.svh"

module tmc_presc (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Configuration
    input wire tmc_pkg::tmc_mode_t mode_i,
    input wire logic [1:0] code_i,
    input wire logic run_i,
    input wire logic sleep_i,
    // Timing strobes
    input wire logic icyc_i,
    input wire logic qsamp_i,
    input wire logic clr_i,
    // Synchronised count input level
    input wire logic ext_lvl_i,
    // Count advance pulse
    output logic adv_o
);
    import tmc_pkg::*;

    typedef struct packed {
        logic [2:0] pres;
        logic ext_prev;
        logic samp;
        logic adv;
    } tmc_presc_st_t;

    tmc_presc_st_t s_q;
    tmc_presc_st_t s_d;

    function automatic logic [2:0] ps_mask(input logic [1:0] code);
        ps_mask = 3'h0;
        case (code)
            2'h1: ps_mask = 3'h1;
            2'h2: ps_mask = 3'h3;
            2'h3: ps_mask = 3'h7;
            default: ps_mask = 3'h0;
        endcase
    endfunction

    logic tick;
    logic div_tick;
    logic presc_lvl;

    always_comb begin
        s_d = s_q;
        s_d.adv = 1'b0;
        s_d.ext_prev = ext_lvl_i;
        // Source edge: instruction cycle or rising external edge
        if (mode_i == TMC_MODE_TIMER) begin
            tick = icyc_i && run_i;
        end else begin
            tick = ext_lvl_i && !s_q.ext_prev && run_i;
        end
        div_tick = tick && ((s_q.pres & ps_mask(code_i)) == ps_mask(code_i));
        // Divided level, symmetric for ratios above one
        if (code_i == 2'h0) begin
            presc_lvl = ext_lvl_i;
        end else begin
            presc_lvl = s_q.pres[code_i - 2'h1];
        end
        // Ripple style divider keeps counting in sleep on external edges; in timer mode no instruction tick arrives
        if (clr_i) begin
            s_d.pres = 3'h0;
        end else if (tick) begin
            s_d.pres = s_q.pres + 3'h1;
        end
        case (mode_i)
            TMC_MODE_SYNC: begin
                // Sampled after the divider on Q2 and Q4
                if (qsamp_i && !sleep_i) begin
                    s_d.samp = presc_lvl;
                    s_d.adv = presc_lvl && !s_q.samp && run_i;
                end
            end
            TMC_MODE_ASYNC: begin
                s_d.adv = div_tick;
            end
            default: begin
                s_d.adv = div_tick;
            end
        endcase
        if (rst_i) begin
            s_d = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        s_q <= s_d;
    end

    assign adv_o = s_q.adv;

endmodule // tmc_presc

// File: rtl/tmc_timer.sv
`timescale 1ns/10ps
`include "tmc_cfg.svh"

// Behaviour
// - Two count bytes form one 16-bit up counter wrapping ffff to 0000
// - Overflow latches the flag; interrupt out only when enable bit set
// - Control bit 1 picks instruction clock or rising external edges
// - Control bits 5:4 select prescale 1:1, 1:2, 1:4, 1:8
// - Control bit 3 enables the crystal oscillator, else it is off
// - With oscillator on, both oscillator pins are forced to inputs
// - Control bit 2 set skips sync, clear syncs; ignored in timer mode
// - Counter edges come from oscillator pin if enabled, else clock pin
// - Prescaler is a ripple divider; sync follows the prescaler
// - Synced counter mode stops in sleep while prescaler keeps counting
// - Sync samples prescaler output on Q2 and Q4 phases
// - Async counter mode runs in sleep and its overflow can wake
// - Async counter mode is not a capture or compare time base
// - Capture/compare reset input clears the 16-bit count, except in async counter mode
// - Control bits 7:6 read zero and ignore writes
// - Control clears on power-on reset; count bytes never reset
// - Any write to a count byte clears the prescaler
// - Count write beats a compare reset; that reset never sets the flag

module tmc_timer (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // AXI4-Lite write address
    input wire logic [`TMC_ADDR_W-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    // AXI4-Lite write response
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // AXI4-Lite read address
    input wire logic [`TMC_ADDR_W-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    // AXI4-Lite read data
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // Core side
    input wire logic sleep_i,
    input wire logic ccp_reset_i,
    input wire logic [1:0] port_dir_i,
    // Pins
    input wire logic ext_count_clock_pin_i,
    input wire logic osc_input_pin_i,
    // Outputs
    output logic overflow_irq_o,
    output logic wake_o,
    output logic timebase_ok_o,
    output logic [1:0] port_oe_o,
    output logic osc_amp_en_o
);
    import tmc_pkg::*;

    typedef struct packed {
        tmc_wr_st_t ws;
        tmc_rd_st_t rs;
        logic [`TMC_IDX_W-1:0] waddr;
        logic [7:0] wdata;
        logic wlane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl;
        logic [15:0] cnt;
        logic flag;
        logic ien;
        logic [1:0] qph;
        logic icyc;
        logic qsamp;
        logic pclr;
        logic ext_m;
        logic ext_s;
        logic irq;
        logic wake;
        logic tbase;
        logic [1:0] port_oe;
        logic osc_amp;
    } tmc_top_st_t;

    tmc_top_st_t s_q;
    tmc_top_st_t s_d;

    function automatic tmc_sel_t reg_sel(
        input logic [`TMC_ADDR_W-1:0] addr
    );
        reg_sel = TMC_SEL_NONE;
        case (addr[`TMC_ADDR_W-1:2])
            `TMC_FLAG_IDX: reg_sel = TMC_SEL_FLAG;
            `TMC_CNTL_IDX: reg_sel = TMC_SEL_CNTL;
            `TMC_CNTH_IDX: reg_sel = TMC_SEL_CNTH;
            `TMC_CTRL_IDX: reg_sel = TMC_SEL_CTRL;
            `TMC_IEN_IDX: reg_sel = TMC_SEL_IEN;
            default: reg_sel = TMC_SEL_NONE;
        endcase
    endfunction

    logic p_adv;
    tmc_mode_t mode;
    logic osc_en;
    logic run;
    logic aw_hs;
    logic w_hs;
    logic do_wr;
    logic [`TMC_ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane;
    tmc_sel_t wr_sel;
    tmc_sel_t rd_sel;
    logic wr_cnt;

    always_comb begin
        s_d = s_q;
        osc_en = s_q.ctrl[`TMC_B_OSC];
        run = s_q.ctrl[`TMC_B_RUN];
        // Mode decode, sync bit ignored for the internal clock
        if (!s_q.ctrl[`TMC_B_CS]) begin
            mode = TMC_MODE_TIMER;
        end else if (s_q.ctrl[`TMC_B_SYNC]) begin
            mode = TMC_MODE_ASYNC;
        end else begin
            mode = TMC_MODE_SYNC;
        end

        // Pin select ahead of the two-stage synchroniser
        s_d.ext_m = osc_en ? osc_input_pin_i : ext_count_clock_pin_i;
        s_d.ext_s = s_q.ext_m;

        // Phase clocks; instruction tick on Q4, none during sleep
        s_d.qph = s_q.qph + 2'h1;
        s_d.icyc = (s_q.qph == `TMC_Q4) && !sleep_i;
        s_d.qsamp = (s_q.qph == `TMC_Q2) || (s_q.qph == `TMC_Q4);
        s_d.pclr = 1'b0;

        // Write channel handshakes
        aw_hs = awvalid_i && s_q.awready;
        w_hs = wvalid_i && s_q.wready;
        do_wr = 1'b0;
        wr_addr = awaddr_i;
        wr_data = wdata_i[7:0];
        wr_lane = wstrb_i[0];
        case (s_q.ws)
            TMC_WS_IDLE: begin
                if (aw_hs && w_hs) begin
                    do_wr = 1'b1;
                    s_d.ws = TMC_WS_RESP;
                end else if (aw_hs) begin
                    s_d.waddr = awaddr_i[`TMC_ADDR_W-1:2];
                    s_d.ws = TMC_WS_ADDR;
                end else if (w_hs) begin
                    s_d.wdata = wdata_i[7:0];
                    s_d.wlane = wstrb_i[0];
                    s_d.ws = TMC_WS_DATA;
                end
            end
            TMC_WS_ADDR: begin
                wr_addr = {s_q.waddr, 2'h0};
                if (w_hs) begin
                    do_wr = 1'b1;
                    s_d.ws = TMC_WS_RESP;
                end
            end
            TMC_WS_DATA: begin
                wr_data = s_q.wdata;
                wr_lane = s_q.wlane;
                if (aw_hs) begin
                    do_wr = 1'b1;
                    s_d.ws = TMC_WS_RESP;
                end
            end
            TMC_WS_RESP: begin
                if (bready_i) begin
                    s_d.ws = TMC_WS_IDLE;
                end
            end
            default: begin
                s_d.ws = TMC_WS_IDLE;
            end
        endcase
        wr_sel = reg_sel(wr_addr);
        if (do_wr) begin
            s_d.bresp = (wr_sel == TMC_SEL_NONE) ? `TMC_RESP_ERR
                                                 : `TMC_RESP_OK;
        end
        s_d.awready = (s_d.ws == TMC_WS_IDLE) || (s_d.ws == TMC_WS_DATA);
        s_d.wready = (s_d.ws == TMC_WS_IDLE) || (s_d.ws == TMC_WS_ADDR);
        s_d.bvalid = (s_d.ws == TMC_WS_RESP);

        // Register writes, byte lane 0 carries the data
        wr_cnt = do_wr && wr_lane &&
                 ((wr_sel == TMC_SEL_CNTL) || (wr_sel == TMC_SEL_CNTH));
        if (do_wr && wr_lane) begin
            case (wr_sel)
                TMC_SEL_CTRL: begin
                    s_d.ctrl = wr_data & `TMC_CTRL_MASK;
                end
                TMC_SEL_IEN: begin
                    s_d.ien = wr_data[`TMC_B_OVF];
                end
                TMC_SEL_FLAG: begin
                    s_d.flag = wr_data[`TMC_B_OVF];
                end
                default: begin
                    s_d.ien = s_q.ien;
                end
            endcase
        end

        // Count update: write first, then compare reset, then advance
        if (wr_cnt) begin
            if (wr_sel == TMC_SEL_CNTL) begin
                s_d.cnt[7:0] = wr_data;
            end else begin
                s_d.cnt[15:8] = wr_data;
            end
            s_d.pclr = 1'b1;
        end else if (ccp_reset_i && (mode != TMC_MODE_ASYNC)) begin
            s_d.cnt = `TMC_CNT_ZERO;
            s_d.pclr = 1'b1;
        end else if (p_adv && run) begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_q.cnt == `TMC_CNT_MAX) begin
                s_d.flag = 1'b1;
            end
        end

        // Read channel
        rd_sel = reg_sel(araddr_i);
        case (s_q.rs)
            TMC_RS_IDLE: begin
                if (arvalid_i && s_q.arready) begin
                    s_d.rs = TMC_RS_DATA;
                    s_d.rresp = `TMC_RESP_OK;
                    s_d.rdata = 32'h0000_0000;
                    case (rd_sel)
                        TMC_SEL_FLAG: s_d.rdata[`TMC_B_OVF] = s_q.flag;
                        TMC_SEL_IEN: s_d.rdata[`TMC_B_OVF] = s_q.ien;
                        TMC_SEL_CNTL: s_d.rdata[7:0] = s_q.cnt[7:0];
                        TMC_SEL_CNTH: s_d.rdata[7:0] = s_q.cnt[15:8];
                        TMC_SEL_CTRL: s_d.rdata[7:0] = s_q.ctrl;
                        default: s_d.rresp = `TMC_RESP_ERR;
                    endcase
                end
            end
            TMC_RS_DATA: begin
                if (rready_i) begin
                    s_d.rs = TMC_RS_IDLE;
                end
            end
            default: begin
                s_d.rs = TMC_RS_IDLE;
            end
        endcase
        s_d.arready = (s_d.rs == TMC_RS_IDLE);
        s_d.rvalid = (s_d.rs == TMC_RS_DATA);

        // Interrupt and wake only through the enable bit
        s_d.irq = s_d.flag && s_d.ien;
        s_d.wake = s_d.flag && s_d.ien && sleep_i;
        // Time base valid only outside async counter mode
        s_d.tbase = (mode != TMC_MODE_ASYNC);
        // Oscillator pins forced to inputs while enabled
        s_d.port_oe = osc_en ? 2'h0 : ~port_dir_i;
        // Inverter and feedback on only when enabled
        s_d.osc_amp = osc_en;

        // Power-on reset clears control, keeps the count
        if (rst_i) begin
            s_d = '0;
            s_d.ctrl = `TMC_CTRL_RST;
            s_d.cnt = s_q.cnt;
            s_d.ws = TMC_WS_IDLE;
            s_d.rs = TMC_RS_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        s_q <= s_d;
    end

    tmc_presc u_presc (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .mode_i(mode),
        .code_i(s_q.ctrl[`TMC_B_PS_HI:`TMC_B_PS_LO]),
        .run_i(run),
        .sleep_i(sleep_i),
        .icyc_i(s_q.icyc),
        .qsamp_i(s_q.qsamp),
        .clr_i(s_q.pclr),
        .ext_lvl_i(s_q.ext_s),
        .adv_o(p_adv)
    );

    assign awready_o = s_q.awready;
    assign wready_o = s_q.wready;
    assign bvalid_o = s_q.bvalid;
    assign bresp_o = s_q.bresp;
    assign arready_o = s_q.arready;
    assign rvalid_o = s_q.rvalid;
    assign rdata_o = s_q.rdata;
    assign rresp_o = s_q.rresp;
    assign overflow_irq_o = s_q.irq;
    assign wake_o = s_q.wake;
    assign timebase_ok_o = s_q.tbase;
    assign port_oe_o = s_q.port_oe;
    assign osc_amp_en_o = s_q.osc_amp;

endmodule // tmc_timer

// File: bench/tmc_timer_asserts.sv
`timescale 1ns/10ps

module tmc_timer_asserts (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Bus
    input wire logic awvalid_i,
    input wire logic awready_o,
    input wire logic wvalid_i,
    input wire logic wready_o,
    input wire logic bvalid_o,
    input wire logic bready_i,
    input wire logic rvalid_o,
    input wire logic [31:0] rdata_o,
    // Core and pins
    input wire logic sleep_i,
    input wire logic [1:0] port_dir_i,
    input wire logic [1:0] port_oe_o,
    input wire logic osc_amp_en_o,
    input wire logic overflow_irq_o,
    input wire logic wake_o
);
    logic live_q = 1'b0;

    always_ff @(posedge mclk_i) begin
        live_q <= !rst_i;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i || !live_q);

    chk_port_force: assert property (
        osc_amp_en_o |-> port_oe_o == 2'h0)
        else $error("pins driven with oscillator on");
    chk_port_dir: assert property (
        !osc_amp_en_o |-> port_oe_o == ~$past(port_dir_i))
        else $error("pin enables do not follow direction bits");
    chk_wake_irq: assert property (
        wake_o |-> overflow_irq_o)
        else $error("wake without interrupt");
    chk_wake_sleep: assert property (
        wake_o |-> $past(sleep_i))
        else $error("wake outside sleep");
    chk_irq_fall: assert property (
        $fell(overflow_irq_o) |-> bvalid_o)
        else $error("interrupt dropped without a write");
    chk_b_answer: assert property (
        awvalid_i && awready_o && wvalid_i && wready_o |=> bvalid_o)
        else $error("write response late");
    chk_b_once: assert property (
        bvalid_o && bready_i |=> !bvalid_o)
        else $error("write response repeated");
    chk_r_upper: assert property (
        rvalid_o |-> rdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
endmodule // tmc_timer_asserts

bind tmc_timer tmc_timer_asserts u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .wvalid_i(wvalid_i),
    .wready_o(wready_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .rvalid_o(rvalid_o), .rdata_o(rdata_o), .sleep_i(sleep_i),
    .port_dir_i(port_dir_i), .port_oe_o(port_oe_o),
    .osc_amp_en_o(osc_amp_en_o), .overflow_irq_o(overflow_irq_o),
    .wake_o(wake_o));

// File: bench/tmc_clk_src.sv
`timescale 1ns/10ps

module tmc_clk_src (
    // Clock
    input wire logic mclk_i,
    // Control
    input wire logic en_i,
    // Pin and edge count
    output logic pin_o,
    output int rises_o
);
    int ph_q = 0;

    initial begin
        pin_o = 1'b0;
        rises_o = 0;
    end

    // Three clocks high, three low; stands low when idle
    always @(posedge mclk_i) begin
        if (!en_i && ph_q == 0 && !pin_o) begin
            pin_o <= 1'b0;
        end else if (ph_q == 2) begin
            ph_q <= 0;
            pin_o <= !pin_o;
            if (!pin_o) begin
                rises_o <= rises_o + 1;
            end
        end else begin
            ph_q <= ph_q + 1;
        end
    end
endmodule // tmc_clk_src

// File: bench/tmc_timer_test.sv
`timescale 1ns/10ps
`include "tmc_cfg.svh"

module tmc_timer_test;
    import tmc_pkg::*;
    localparam logic [11:0] A_FLG = {`TMC_FLAG_IDX, 2'b00};
    localparam logic [11:0] A_CL = {`TMC_CNTL_IDX, 2'b00};
    localparam logic [11:0] A_CH = {`TMC_CNTH_IDX, 2'b00};
    localparam logic [11:0] A_CT = {`TMC_CTRL_IDX, 2'b00};
    localparam logic [11:0] A_EN = {`TMC_IEN_IDX, 2'b00};
    logic mclk_i = 0, rst_i = 1, awvalid_i = 0, wvalid_i = 0, bready_i = 0;
    logic arvalid_i = 0, rready_i = 0, sleep_i = 0, ccp_reset_i = 0;
    logic [11:0] awaddr_i = 0, araddr_i = 0;
    logic [31:0] wdata_i = 0, rdata_o, d;
    logic [1:0] port_dir_i = 2'h3, bresp_o, rresp_o, port_oe_o, en = 0, r, bq;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic overflow_irq_o, wake_o, timebase_ok_o, osc_amp_en_o, ext, osc;
    logic [15:0] v, w;
    int miscompares = 0, tests_run = 0, rises [2];

    always #10 mclk_i = ~mclk_i;

    tmc_timer dut (.mclk_i(mclk_i), .rst_i(rst_i), .awaddr_i(awaddr_i),
        .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
        .wstrb_i(4'h1), .wvalid_i(wvalid_i), .wready_o(wready_o),
        .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
        .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
        .rready_i(rready_i), .sleep_i(sleep_i), .ccp_reset_i(ccp_reset_i),
        .port_dir_i(port_dir_i), .ext_count_clock_pin_i(ext),
        .osc_input_pin_i(osc), .overflow_irq_o(overflow_irq_o),
        .wake_o(wake_o), .timebase_ok_o(timebase_ok_o),
        .port_oe_o(port_oe_o), .osc_amp_en_o(osc_amp_en_o));
    tmc_clk_src u_ext (.mclk_i(mclk_i), .en_i(en[0]), .pin_o(ext),
        .rises_o(rises[0]));
    tmc_clk_src u_osc (.mclk_i(mclk_i), .en_i(en[1]), .pin_o(osc),
        .rises_o(rises[1]));

    task close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Count within one tick either side
    task near(input logic [15:0] got, input logic [15:0] exp);
        chk({31'h0, (got - exp + 16'h0001) <= 16'h0002}, 32'h1);
    endtask

    task wr(input logic [11:0] a, input logic [7:0] dt);
        int n;
        logic aw, wd;
        @(posedge mclk_i);
        awaddr_i <= a;
        wdata_i <= {24'h00_0000, dt};
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        aw = 0;
        wd = 0;
        n = 0;
        while (!(aw && wd) && n < 64) begin
            @(posedge mclk_i);
            n++;
            if (!aw && awready_o === 1'b1) begin
                aw = 1;
                awvalid_i <= 1'b0;
            end
            if (!wd && wready_o === 1'b1) begin
                wd = 1;
                wvalid_i <= 1'b0;
            end
        end
        while (bvalid_o !== 1'b1 && n < 64) begin
            @(posedge mclk_i);
            n++;
        end
        bq = bresp_o;
        if (n >= 64) begin
            miscompares++;
        end
        bready_i <= 1'b0;
    endtask

    task rd(input logic [11:0] a);
        int n;
        @(posedge mclk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (arready_o !== 1'b1 && n < 64);
        arvalid_i <= 1'b0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (rvalid_o !== 1'b1 && n < 64);
        d = rdata_o;
        r = rresp_o;
        if (n >= 64) begin
            miscompares++;
        end
        rready_i <= 1'b0;
    endtask

    task cnt();
        rd(A_CH);
        v[15:8] = d[7:0];
        rd(A_CL);
        v[7:0] = d[7:0];
    endtask

    task cnt_set(input logic [15:0] c);
        wr(A_CH, c[15:8]);
        wr(A_CL, c[7:0]);
    endtask

    task pulses(input logic [1:0] m, input int n);
        int b, k;
        b = rises[m[1]];
        k = 0;
        en <= m;
        while (rises[m[1]] != b + n && k < 2000) begin
            @(posedge mclk_i);
            k++;
        end
        if (k >= 2000) begin
            miscompares++;
        end
        en <= 2'h0;
        repeat (20) @(posedge mclk_i);
    endtask

    task t_regs();
        rd(A_CT);
        chk(d, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        wr(A_CT, 8'hff);
        chk(bq, 32'h0000_0000);
        rd(A_CT);
        chk(d, 32'h0000_003f);
        wr(A_CT, 8'h00);
        rd(12'h004);
        chk(d, 32'h0000_0000);
        chk(r, 32'h0000_0002);
        wr(12'h004, 8'h55);
        chk(bq, 32'h0000_0002);
    endtask

    task t_presc();
        for (int c = 0; c < 4; c++) begin
            cnt_set(16'h0000);
            wr(A_CT, {2'b00, c[1:0], 1'b0, c[0], 2'b01});
            repeat (157) @(posedge mclk_i);
            chk(timebase_ok_o, 32'h1);
            wr(A_CT, 8'h00);
            cnt();
            near(v, 16'd40 >> c);
        end
        repeat (40) @(posedge mclk_i);
        w = v;
        cnt();
        chk(v, w);
    endtask

    task t_wrap();
        cnt_set(16'hfffe);
        wr(A_FLG, 8'h00);
        wr(A_EN, 8'h01);
        wr(A_CT, 8'h01);
        repeat (20) @(posedge mclk_i);
        wr(A_CT, 8'h00);
        cnt();
        near(v, 16'hfffe + 16'd5);
        chk(overflow_irq_o, 32'h1);
        wr(A_EN, 8'h00);
        repeat (2) @(posedge mclk_i);
        chk(overflow_irq_o, 32'h0);
        rd(A_FLG);
        chk(d, 32'h0000_0001);
        wr(A_EN, 8'h01);
        wr(A_FLG, 8'h00);
        repeat (2) @(posedge mclk_i);
        chk(overflow_irq_o, 32'h0);
    endtask

    task t_ccp();
        cnt_set(16'hffff);
        @(posedge mclk_i);
        ccp_reset_i <= 1'b1;
        @(posedge mclk_i);
        ccp_reset_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        cnt();
        chk(v, 32'h0000_0000);
        fork
            wr(A_CL, 8'h77);
            begin
                @(posedge mclk_i);
                ccp_reset_i <= 1'b1;
                @(posedge mclk_i);
                ccp_reset_i <= 1'b0;
            end
        join
        repeat (3) @(posedge mclk_i);
        cnt();
        chk(v, 32'h0000_0077);
        rd(A_FLG);
        chk(d, 32'h0000_0000);
    endtask

    task t_ext();
        cnt_set(16'h0000);
        wr(A_CT, 8'h13);
        pulses(2'b01, 16);
        cnt();
        chk(v, 32'h0000_0008);
        pulses(2'b01, 1);
        cnt_set(16'h0000);
        pulses(2'b01, 1);
        cnt();
        chk(v, 32'h0000_0001);
        port_dir_i <= 2'b01;
        wr(A_CT, 8'h0b);
        repeat (2) @(posedge mclk_i);
        chk(port_oe_o, 32'h0);
        chk(osc_amp_en_o, 32'h1);
        cnt_set(16'h0000);
        pulses(2'b10, 10);
        pulses(2'b01, 5);
        cnt();
        chk(v, 32'h0000_000a);
        wr(A_CT, 8'h03);
        repeat (2) @(posedge mclk_i);
        chk(osc_amp_en_o, 32'h0);
        chk(port_oe_o, 32'h2);
        sleep_i <= 1'b1;
        cnt_set(16'h0000);
        pulses(2'b01, 8);
        cnt();
        chk(v, 32'h0000_0000);
        wr(A_CT, 8'h07);
        cnt_set(16'hfffc);
        wr(A_FLG, 8'h00);
        pulses(2'b01, 8);
        chk(timebase_ok_o, 32'h0);
        chk(wake_o, 32'h1);
        sleep_i <= 1'b0;
        cnt();
        chk(v, 32'h0000_0004);
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        t_regs();
        t_presc();
        t_wrap();
        t_ccp();
        t_ext();
        close_out();
    end
endmodule // tmc_timer_test
